/* hw/ebpi_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
module ebpi_bus_if
  import ebpi_pkg::*;
#(
  parameter int unsigned NCS = 3
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_nrst,
  input  wire logic                i_ce,
  input  wire logic                i_req_valid,
  input  wire ebpi_req_s           i_req,
  output logic                     o_busy,
  output logic                     o_done,
  output logic [DATA_W-1:0]        o_rdata,
  input  wire logic                i_bus16,
  input  wire logic                i_int_rd_enable_n,
  input  wire logic                i_read_pin_function_select,
  input  wire ebpi_area_s [NCS-1:0] i_cs_area,
  input  wire logic                i_ext_interrupt_zero_edge_mode,
  input  wire logic                i_ext_interrupt_zero,
  output logic                     o_ext_interrupt_zero_req,
  input  wire logic [7:0]          i_mux_addr_data_low,
  output logic [7:0]               o_mux_addr_data_low,
  output logic                     o_mux_addr_data_low_oe,
  input  wire logic [7:0]          i_mux_addr_data_high,
  output logic [7:0]               o_mux_addr_data_high,
  output logic                     o_mux_addr_data_high_oe,
  output logic [7:0]               o_addr_mid_byte,
  output logic [7:0]               o_addr_upper_byte,
  output logic                     o_bus_oe,
  output logic                     o_read_strobe_n,
  output logic                     o_write_strobe_n,
  output logic                     o_high_write_strobe_n,
  output logic                     o_read_write,
  output logic [NCS-1:0]           o_chip_select_n,
  input  wire logic                i_wait_n,
  input  wire logic                i_bus_hold_request_n,
  output logic                     o_bus_hold_grant_n
);
  // Decode and reset values are built for exactly three chip selects
  if (NCS != NUM_CS) begin : g_ncs_check
    $error("ebpi_bus_if: chip select count must be 3");
  end

  ebpi_state_e state_r, state_nxt;
  ebpi_req_s   req_r, req_nxt;
  logic [7:0]  ad_lo_nxt, ad_hi_nxt, mid_nxt, up_nxt;
  logic        ad_lo_oe_nxt, ad_hi_oe_nxt, bus_oe_nxt, rd_n_nxt, wr_n_nxt, hwr_n_nxt, rw_nxt;
  logic        grant_n_nxt, done_nxt, ext_interrupt_zero_prev_r;
  logic [NCS-1:0]    cs_n_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  wire logic           start     = i_req_valid && i_bus_hold_request_n;
  wire logic           ext       = !req_r.internal;
  wire logic           rd_strobe = !req_r.write && (ext || (!i_int_rd_enable_n && i_read_pin_function_select));
  wire logic           wr_ext    = req_r.write && ext;
  wire logic           ext_interrupt_zero_nxt  = i_ext_interrupt_zero_edge_mode ? (i_ext_interrupt_zero && !ext_interrupt_zero_prev_r)
                                                    : i_ext_interrupt_zero;
  logic [NCS-1:0]      cs_hit;
  logic [NCS-1:0]      new_hit;

  always_comb begin
    for (int i = 0; i < NCS; i++) begin
      cs_hit[i]  = ebpi_area_hit(req_r.addr, i_cs_area[i]);
      new_hit[i] = ebpi_area_hit(i_req.addr, i_cs_area[i]);
    end
  end

  always_comb begin
    state_nxt    = state_r;
    req_nxt      = req_r;
    ad_lo_nxt    = o_mux_addr_data_low;
    ad_hi_nxt    = o_mux_addr_data_high;
    mid_nxt      = o_addr_mid_byte;
    up_nxt       = o_addr_upper_byte;
    ad_lo_oe_nxt = o_mux_addr_data_low_oe;
    ad_hi_oe_nxt = o_mux_addr_data_high_oe;
    bus_oe_nxt   = o_bus_oe;
    rd_n_nxt     = o_read_strobe_n;
    wr_n_nxt     = o_write_strobe_n;
    hwr_n_nxt    = o_high_write_strobe_n;
    rw_nxt       = o_read_write;
    cs_n_nxt     = o_chip_select_n;
    grant_n_nxt  = o_bus_hold_grant_n;
    done_nxt     = 1'b0;
    rdata_nxt    = o_rdata;
    unique case (state_r)
      ST_IDLE: begin
        if (!i_bus_hold_request_n) begin
          state_nxt    = ST_FLOAT;
          bus_oe_nxt   = 1'b0;
          ad_lo_oe_nxt = 1'b0;
          ad_hi_oe_nxt = 1'b0;
          cs_n_nxt     = RST_CS_N;
        end else if (start) begin
          state_nxt    = ST_ADDR;
          req_nxt      = i_req;
          ad_lo_nxt    = i_req.addr[LO_LSB +: 8];
          ad_hi_nxt    = i_req.addr[MID_LSB +: 8];
          mid_nxt      = i_req.addr[MID_LSB +: 8];
          up_nxt       = i_req.addr[UP_LSB +: 8];
          ad_lo_oe_nxt = !i_req.internal;
          ad_hi_oe_nxt = !i_req.internal;
          rw_nxt       = !i_req.write;
          cs_n_nxt     = i_req.internal ? RST_CS_N : ~new_hit;
        end
      end
      ST_ADDR: begin
        state_nxt    = ST_STRB;
        rd_n_nxt     = !rd_strobe;
        wr_n_nxt     = !(wr_ext && req_r.be[0]);
        hwr_n_nxt    = !(wr_ext && req_r.be[1] && i_bus16);
        ad_lo_nxt    = req_r.wdata[7:0];
        ad_lo_oe_nxt = wr_ext;
        // Narrow mode keeps the middle address byte on the high lines for the whole cycle
        ad_hi_nxt    = i_bus16 ? req_r.wdata[15:8] : req_r.addr[MID_LSB +: 8];
        ad_hi_oe_nxt = i_bus16 ? wr_ext : ext;
      end
      ST_STRB: begin
        if (i_wait_n) begin
          state_nxt    = ST_IDLE;
          done_nxt     = 1'b1;
          rdata_nxt    = req_r.internal ? RST_WORD
                         : {(i_bus16 ? i_mux_addr_data_high : RST_BYTE), i_mux_addr_data_low};
          rd_n_nxt     = RST_STROBE;
          wr_n_nxt     = RST_STROBE;
          hwr_n_nxt    = RST_STROBE;
          rw_nxt       = RST_RW;
          cs_n_nxt     = RST_CS_N;
          ad_lo_oe_nxt = 1'b0;
          ad_hi_oe_nxt = 1'b0;
        end
      end
      ST_FLOAT: begin
        state_nxt   = ST_HOLD;
        grant_n_nxt = 1'b0;
      end
      ST_HOLD: begin
        if (i_bus_hold_request_n) begin
          state_nxt   = ST_IDLE;
          grant_n_nxt = 1'b1;
          bus_oe_nxt  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r                 <= ST_IDLE;
      req_r                   <= '0;
      o_mux_addr_data_low     <= RST_BYTE;
      o_mux_addr_data_high    <= RST_BYTE;
      o_addr_mid_byte         <= RST_BYTE;
      o_addr_upper_byte       <= RST_BYTE;
      o_mux_addr_data_low_oe  <= 1'b0;
      o_mux_addr_data_high_oe <= 1'b0;
      o_bus_oe                <= 1'b1;
      o_read_strobe_n         <= RST_STROBE;
      o_write_strobe_n        <= RST_STROBE;
      o_high_write_strobe_n   <= RST_STROBE;
      o_read_write            <= RST_RW;
      o_chip_select_n         <= RST_CS_N;
      o_bus_hold_grant_n      <= 1'b1;
      o_done                  <= 1'b0;
      o_busy                  <= 1'b0;
      o_rdata                 <= RST_WORD;
      o_ext_interrupt_zero_req              <= 1'b0;
      ext_interrupt_zero_prev_r             <= 1'b0;
    end else if (i_ce) begin
      state_r                 <= state_nxt;
      req_r                   <= req_nxt;
      o_mux_addr_data_low     <= ad_lo_nxt;
      o_mux_addr_data_high    <= ad_hi_nxt;
      o_addr_mid_byte         <= mid_nxt;
      o_addr_upper_byte       <= up_nxt;
      o_mux_addr_data_low_oe  <= ad_lo_oe_nxt;
      o_mux_addr_data_high_oe <= ad_hi_oe_nxt;
      o_bus_oe                <= bus_oe_nxt;
      o_read_strobe_n         <= rd_n_nxt;
      o_write_strobe_n        <= wr_n_nxt;
      o_high_write_strobe_n   <= hwr_n_nxt;
      o_read_write            <= rw_nxt;
      o_chip_select_n         <= cs_n_nxt;
      o_bus_hold_grant_n      <= grant_n_nxt;
      o_done                  <= done_nxt;
      o_busy                  <= state_nxt != ST_IDLE;
      o_rdata                 <= rdata_nxt;
      o_ext_interrupt_zero_req              <= ext_interrupt_zero_nxt;
      ext_interrupt_zero_prev_r             <= i_ext_interrupt_zero;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  a_hold_floats_pins: assert property (!o_bus_hold_grant_n |-> !o_bus_oe && !o_mux_addr_data_low_oe
                                       && !o_mux_addr_data_high_oe) else $error("pins driven while granted");
  a_grant_after_float: assert property ($fell(o_bus_hold_grant_n) |-> $past(!o_bus_oe) && $past(state_r) == ST_FLOAT)
    else $error("grant before pins floated");
  a_cs_high_granted: assert property (!o_bus_hold_grant_n |-> o_chip_select_n == RST_CS_N)
    else $error("chip select low while granted");
  a_cs_area_decode: assert property (state_r == ST_STRB && ext |-> o_chip_select_n == ~cs_hit)
    else $error("chip select does not match area");
  a_wait_stretches: assert property (state_r == ST_STRB && !i_wait_n && i_ce |=> state_r == ST_STRB && !o_done)
    else $error("cycle ended under wait");
  a_low_write_data: assert property (!o_write_strobe_n |-> !o_read_write && o_mux_addr_data_low_oe
                                     && o_mux_addr_data_low == req_r.wdata[7:0]) else $error("low write data wrong");
  a_high_write_wide: assert property (!o_high_write_strobe_n |-> i_bus16 && o_mux_addr_data_high_oe
                                      && o_mux_addr_data_high == req_r.wdata[15:8]) else $error("high write wrong");
  a_read_lines_free: assert property (!o_read_strobe_n |-> o_read_write && !o_mux_addr_data_low_oe)
    else $error("data lines driven during read");
  a_int_read_strobe: assert property (state_r == ST_ADDR && req_r.internal && !req_r.write && i_ce
                                      && !i_int_rd_enable_n && i_read_pin_function_select |=> !o_read_strobe_n)
    else $error("internal read strobe missing");
  a_addr_phase_low: assert property (state_r == ST_ADDR && ext |-> o_mux_addr_data_low_oe
                                     && o_mux_addr_data_low == req_r.addr[7:0]) else $error("low address wrong");
  a_upper_addr_out: assert property (state_r inside {ST_ADDR, ST_STRB} |-> o_addr_upper_byte == req_r.addr[23:16])
    else $error("upper address wrong");
  a_ext_interrupt_zero_edge_pulse: assert property (i_ce && i_ext_interrupt_zero_edge_mode && $rose(i_ext_interrupt_zero) |=> o_ext_interrupt_zero_req)
    else $error("edge interrupt missed");

  c_ext_read:   cover property (state_r == ST_STRB && !o_read_strobe_n ##1 o_done);
  c_wait_write: cover property (!o_write_strobe_n && !i_wait_n ##1 !o_write_strobe_n);
  c_bus_hold:   cover property ($fell(o_bus_hold_grant_n) ##[1:20] $rose(o_bus_hold_grant_n));
endmodule // ebpi_bus_if
`default_nettype wire

/* shared/ebpi_pkg.sv */
// Contract
// - The low address byte and the low data byte share the eight low multiplexed lines within each bus cycle.
// - The eight high lines carry either multiplexed upper address and data or the middle address byte only.
// - The upper eight address bits of each access leave on their own dedicated output lines.
// - The read strobe is asserted while external memory is read, so the addressed device drives the data lines.
// - With the internal-read enable at 0 and the read pin function select at 1, reads of internal memory also strobe.
// - The low write strobe is asserted when data on the lower eight data lines is written.
// - A separate high write strobe is asserted when data on the upper eight data lines is written.
// - An external device may hold the wait input active and the bus cycle is stretched for as long as it does.
// - A bus-hold request floats the data lines, address lines, read and write strobes and all three chip selects; the code drives the chip selects high.
// - After a bus-hold request the grant output is asserted to acknowledge that the pins are floating.
// - The read/write flag is high during read or dummy cycles and low during write cycles.
// - Each chip select is driven low while the bus address lies inside the area programmed for it; the code keeps all three high during internal accesses.
// - External interrupt zero triggers either on an active high level or on a rising edge, as programmed.
package ebpi_pkg;
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned NUM_CS     = 3;
  localparam int unsigned LO_LSB     = 0;
  localparam int unsigned MID_LSB    = 8;
  localparam int unsigned UP_LSB     = 16;
  localparam logic        RST_STROBE = 1'b1;
  localparam logic        RST_RW     = 1'b1;
  localparam logic [2:0]  RST_CS_N   = 3'h7;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;

  typedef logic [ADDR_W-1:0] ebpi_addr_t;

  typedef struct packed {
    ebpi_addr_t        addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic [1:0]        be;
    logic              internal;
  } ebpi_req_s;

  typedef struct packed {
    ebpi_addr_t base;
    ebpi_addr_t mask;
  } ebpi_area_s;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STRB, ST_FLOAT, ST_HOLD} ebpi_state_e;

  // Mask bit set means the address bit takes part in the compare
  function automatic logic ebpi_area_hit(input ebpi_addr_t a, input ebpi_area_s ar);
    return ((a ^ ar.base) & ar.mask) == '0;
  endfunction
endpackage

/* bench/ebpi_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebpi_mem_model
  import ebpi_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic [7:0]  i_lo,
  input  wire logic        i_lo_oe,
  input  wire logic [7:0]  i_hi,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_hwr_n,
  input  wire logic [3:0]  i_nwait,
  output logic      [15:0] o_data,
  output logic             o_wait_n
);
  logic [15:0] adr_r;
  logic [15:0] last_r = 16'h0000;
  logic [3:0]  cnt_r  = 4'h0;
  wire         strb   = !(i_rd_n && i_wr_n && i_hwr_n);
  always_ff @(posedge i_clk_sys) begin
    if (i_lo_oe && !strb) adr_r <= {i_hi, i_lo};
    cnt_r  <= strb ? cnt_r + 4'h1 : 4'h0;
    last_r <= o_data;
  end
  // Released lines toggle so a late sample cannot pass by luck
  assign o_data   = !i_rd_n ? adr_r ^ 16'hA5C3 : ~last_r;
  assign o_wait_n = !(strb && cnt_r < i_nwait);
endmodule // ebpi_mem_model
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import ebpi_pkg::*;
;
  logic clk, nrst, ce, rv, b16, ienn, rsel, emode, pin, hold_n, w, in, busy, done, ext_interrupt_zero;
  logic lo_oe, hi_oe, bus_oe, rd_n, wr_n, hwr_n, rw, grant_n, wait_n;
  logic [7:0] lo, hi, mid, up;
  logic [15:0] rdata, mdata;
  logic [2:0] cs;
  logic [3:0] nw;
  logic [23:0] a;
  ebpi_req_s rq;
  ebpi_area_s [2:0] ar;
  int fails = 0, checks = 0, u;
  wire [7:0] ad_lo = lo_oe ? lo : mdata[7:0];
  wire [7:0] ad_hi = hi_oe ? hi : mdata[15:8];

  ebpi_bus_if #(.NCS(3)) u_ebpi_bus_if (.i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce), .i_req_valid(rv),
    .i_req(rq), .o_busy(busy), .o_done(done), .o_rdata(rdata), .i_bus16(b16), .i_int_rd_enable_n(ienn),
    .i_read_pin_function_select(rsel), .i_cs_area(ar), .i_ext_interrupt_zero_edge_mode(emode), .i_ext_interrupt_zero(pin),
    .o_ext_interrupt_zero_req(ext_interrupt_zero), .i_mux_addr_data_low(ad_lo), .o_mux_addr_data_low(lo), .o_mux_addr_data_low_oe(lo_oe),
    .i_mux_addr_data_high(ad_hi), .o_mux_addr_data_high(hi), .o_mux_addr_data_high_oe(hi_oe),
    .o_addr_mid_byte(mid), .o_addr_upper_byte(up), .o_bus_oe(bus_oe), .o_read_strobe_n(rd_n),
    .o_write_strobe_n(wr_n), .o_high_write_strobe_n(hwr_n), .o_read_write(rw), .o_chip_select_n(cs),
    .i_wait_n(wait_n), .i_bus_hold_request_n(hold_n), .o_bus_hold_grant_n(grant_n));
  ebpi_mem_model u_ebpi_mem_model (.i_clk_sys(clk), .i_lo(lo), .i_lo_oe(lo_oe), .i_hi(hi), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_hwr_n(hwr_n), .i_nwait(nw), .o_data(mdata), .o_wait_n(wait_n));

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [2:0] cs_exp(input logic [23:0] x);
    cs_exp = {!x[23], x[23:16] != 8'h01, x[23:16] != 8'h00};
  endfunction
  function automatic logic [15:0] rd_exp(input logic [23:0] x, input logic m);
    rd_exp = x[15:0] ^ 16'hA5C3;
    if (!m) rd_exp[15:8] = 8'h00;
  endfunction

  // One bus cycle, checked phase by phase at falling edges
  task automatic cyc(input logic [15:0] d, input logic [1:0] be);
    int n;
    logic sb;
    n = 0;
    // Wait is only asserted by the far side while a strobe is active
    sb = w ? (be[0] || (be[1] && b16)) : (!in || (!ienn && rsel));
    rq = '{a, d, w, be, in};
    rv = 1'h1;
    @(negedge clk);
    while (busy !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    rv = 1'h0;
    chk("rw", !w, rw);
    chk("cs", in ? 3'h7 : cs_exp(a), cs);
    if (!in) begin
      chk("addr", a, {up, mid, lo});
      chk("hi", a[15:8], hi);
    end
    @(negedge clk);
    chk("rd", w || (in && !(!ienn && rsel)), rd_n);
    chk("wr", !(w && be[0]), wr_n);
    chk("hwr", !(w && be[1] && b16), hwr_n);
    if (w) chk("wdata", {b16 ? d[15:8] : a[15:8], d[7:0]}, {hi, lo});
    n = 0;
    while (done !== 1'h1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("len", 24'(1 + (sb ? nw : 4'h0)), 24'(n));
    if (!w) chk("rdata", in ? 16'h0000 : rd_exp(a, b16), rdata);
    chk("idle", 4'hF, {rw, cs});
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    fails++;
    results();
  end
  initial begin
    {rv, b16, ienn, rsel, emode, pin, w, in, nrst} = '0;
    hold_n = 1'h1;
    ce = 1'h1;
    nw = 4'h0;
    a = 24'h000000;
    rq = '0;
    ar = {{24'h800000, 24'h800000}, {24'h010000, 24'hFF0000}, {24'h000000, 24'hFF0000}};
    u = $urandom(41811);
    repeat (2) @(negedge clk);
    nrst = 1'h1;
    chk("rst", 6'h3F, {rw, cs, grant_n, bus_oe});
    repeat (60) begin
      b16 = 1'($urandom);
      ienn = 1'($urandom);
      rsel = 1'($urandom);
      w = 1'($urandom);
      in = !w && ($urandom % 4 == 0);
      nw = in ? 4'h0 : 4'($urandom % 4);
      a = 24'($urandom);
      u = $urandom % 4;
      a[23:16] = u == 0 ? 8'h00 : u == 1 ? 8'h01 : u == 2 ? 8'hFF : a[23:16];
      cyc(16'($urandom), 2'($urandom));
    end
    hold_n = 1'h0;
    @(negedge clk);
    chk("float", 6'h07, {bus_oe, lo_oe, hi_oe, cs});
    @(negedge clk);
    chk("grant", 1'h0, grant_n);
    hold_n = 1'h1;
    @(negedge clk);
    chk("release", 2'h3, {grant_n, bus_oe});
    emode = 1'h1;
    pin = 1'h1;
    u = 0;
    repeat (6) begin
      @(negedge clk);
      u += ext_interrupt_zero;
    end
    chk("int0e", 1, u);
    emode = 1'h0;
    repeat (2) @(negedge clk);
    chk("int0l", 1'h1, ext_interrupt_zero);
    ce = 1'h0;
    pin = 1'h0;
    repeat (2) @(negedge clk);
    chk("freeze", 1'h1, ext_interrupt_zero);
    ce = 1'h1;
    repeat (2) @(negedge clk);
    chk("int0low", 1'h0, ext_interrupt_zero);
    results();
  end
endmodule // tb
`default_nettype wire
